// ---- src/t1mux_regs.svh ----
// register offsets, field positions and reset values of the timer1 clock source mux
`ifndef T1MUX_REGS_SVH
`define T1MUX_REGS_SVH

// byte offsets on the apb bus
`define T1MUX_OFF_PORT_DATA 8'h00
`define T1MUX_OFF_PORT_DIR 8'h04
`define T1MUX_OFF_CCP_DATA 8'h08
`define T1MUX_OFF_CCP_DIR 8'h0c
`define T1MUX_OFF_CTRL 8'h10
`define T1MUX_OFF_COUNT 8'h14

// timer1_control_reg fields
`define T1MUX_CTRL_RUN 0
`define T1MUX_CTRL_CS 1
`define T1MUX_CTRL_SYNC 2
`define T1MUX_CTRL_OSCEN 3
`define T1MUX_CTRL_WMASK 8'h3f

// reset values
`define T1MUX_RST_CTRL 8'h00
`define T1MUX_RST_PORT_LAT 2'h0
`define T1MUX_RST_PORT_DIR 2'h3
`define T1MUX_RST_CCP_DAT 1'h0
`define T1MUX_RST_CCP_DIR 1'h1
`define T1MUX_RST_COUNT 16'h0000

// secondary oscillator rating, kHz
`define T1MUX_OSC_MAX_KHZ 200
`define T1MUX_OSC_NOM_KHZ 32

`endif

// ---- src/t1mux_pkg.sv ----
// types shared by the timer1 clock source mux
package t1mux_pkg;
  // clock source selection as decoded from the control bits and the ccp pin direction bit
  typedef enum logic [2:0] {
    T1MUX_OFF,
    T1MUX_TIMER,
    T1MUX_EXT,
    T1MUX_FW,
    T1MUX_OSC,
    T1MUX_OSC_IDLE
  } t1mux_mode_e;
  typedef logic [1:0] t1mux_pins_t;
endpackage

// ---- src/t1mux_sync_if.sv ----
// pin level carrier between the mux core and its input synchronisers
`timescale 1ns/1ps
`default_nettype none
interface t1mux_sync_if;
  import t1mux_pkg::*;
  t1mux_pins_t raw; // pin levels, asynchronous
  t1mux_pins_t level; // filtered level per pin
  t1mux_pins_t rise; // one-cycle pulse on a filtered rising edge
  modport sync (input raw, output level, output rise);
  modport user (output raw, input level, input rise);
endinterface
`default_nettype wire

// ---- src/t1mux_sync.sv ----
// three-flop pin synchronisers with agreement filter and rise detect
`timescale 1ns/1ps
`default_nettype none
module t1mux_sync
  import t1mux_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  t1mux_sync_if.sync sif
);
  t1mux_pins_t s1_q; // first stage, read only by s2
  t1mux_pins_t s2_q; // second stage
  t1mux_pins_t s3_q; // third stage
  t1mux_pins_t lvl_q; // accepted level

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pin
      // a change counts once the second and third flops agree
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          lvl_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= sif.raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          lvl_q[g] <= (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
        end
      end
      // edge seen the cycle the two stages agree high
      assign sif.rise[g] = s2_q[g] & s3_q[g] & ~lvl_q[g];
    end
  endgenerate

  assign sif.level = lvl_q;
endmodule // t1mux_sync
`default_nettype wire

// ---- src/t1mux_top.sv ----
// timer1 clock source selection, shared port pin mux and apb registers
// Notes on behaviour
// - off or timer mode: pins plain I/O
// - counter clock: pin, firmware bit, oscillator
// - ext circuit: count pin, bit reads pin
// - firmware: data bit drives pin and clocks
// - ext modes: bit1 output reads latch only
// - select cleared: bit1 driven from latch again
// - osc mode: pins form crystal, clock counter
// - osc mode: data bit reads 0, ignored
// - osc mode: inputs read 0, outputs latches
// - osc mode: writes reach latches, not pins
// - both bits cleared: pins driven from latches
// - run bit starts and stops counting
// - oscillator enabled only by its enable bit
// - oscillator low power, up to 200 kHz
// - oscillator keeps running during sleep
// - timer per cycle, counter per rising edge
`include "t1mux_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module t1mux_top
  import t1mux_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic pin1_i,
  output logic pin1_o,
  output logic pin1_oe_n_o,
  input wire logic pin2_i,
  output logic pin2_o,
  output logic pin2_oe_n_o,
  output logic sec_osc_en_o,
  output logic [15:0] count_o
);
  // software state
  logic [7:0] ctrl_q; // timer1_control_reg
  t1mux_pins_t port_lat_q; // shared_port latches, bit0 = port bit 1
  t1mux_pins_t port_dir_q; // 1 = input
  logic ccp_dat_q; // sw_clock_data_bit latch
  logic ccp_dir_q; // ccp_pin_direction_reg bit0, 1 = input
  logic [15:0] cnt_q; // count_register16
  logic fw_prev_q; // last firmware clock level
  // registered pins and bus answer
  t1mux_pins_t pout_d;
  t1mux_pins_t poe_n_d;
  logic [31:0] prdata_d;
  logic slverr_d;

  // synchronised pins
  t1mux_sync_if sif ();
  assign sif.raw = {pin2_i, pin1_i};
  t1mux_sync u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .sif(sif.sync)
  );

  // control bit decode
  wire run = ctrl_q[`T1MUX_CTRL_RUN];
  wire cs = ctrl_q[`T1MUX_CTRL_CS];
  wire oscen = ctrl_q[`T1MUX_CTRL_OSCEN];

  // mode decode, purely from the live bits so a change acts next cycle
  t1mux_mode_e mode;
  assign mode = !cs ? (oscen ? T1MUX_OSC_IDLE : (run ? T1MUX_TIMER : T1MUX_OFF))
              : oscen ? T1MUX_OSC
              : ccp_dir_q ? T1MUX_EXT : T1MUX_FW;
  wire mode_ext = (mode == T1MUX_EXT);
  wire mode_fw = (mode == T1MUX_FW);
  wire mode_osc = (mode == T1MUX_OSC);
  wire mode_plain = (mode == T1MUX_OFF) || (mode == T1MUX_TIMER);

  // pin ownership: pin1 is taken by any counter mode or the oscillator,
  // pin2 only by the oscillator, which makes both pins inputs
  wire take1 = cs | oscen;
  wire take2 = oscen;

  // pin drive: firmware bit owns pin1 in firmware mode, latches otherwise
  assign pout_d[0] = mode_fw ? ccp_dat_q : port_lat_q[0];
  assign poe_n_d[0] = mode_fw ? 1'b0 : (take1 | port_dir_q[0]);
  assign pout_d[1] = port_lat_q[1];
  assign poe_n_d[1] = take2 | port_dir_q[1];

  // port read-back per pin
  wire [1:0] taken = {take2, take1};
  wire [1:0] port_rd;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_rd
      // taken pin: input reads 0, output reads latch; free pin: input reads its level, output reads latch
      assign port_rd[g] = taken[g] ? (port_dir_q[g] ? 1'b0 : port_lat_q[g])
                        : (port_dir_q[g] ? sif.level[g] : port_lat_q[g]);
    end
  endgenerate

  // sw clock bit read-back
  wire ccp_rd = mode_osc ? 1'b0
              : mode_ext ? sif.level[0]
              : ccp_dat_q;

  // counter clock selection; prescaler is not part of this block
  wire fw_rise = ccp_dat_q & ~fw_prev_q;
  wire cnt_src = (mode == T1MUX_TIMER) ? 1'b1
               : mode_ext ? sif.rise[0]
               : mode_fw ? fw_rise
               : mode_osc ? sif.rise[1]
               : 1'b0;
  wire tick = run & cnt_src;

  // apb decode; answer comes in the first access cycle
  wire setup = psel_i & ~penable_i;
  wire commit = psel_i & penable_i & pready_o;
  wire wr = commit & pwrite_i & ~pslverr_o;
  wire hit_pd = (paddr_i == `T1MUX_OFF_PORT_DATA);
  wire hit_dir = (paddr_i == `T1MUX_OFF_PORT_DIR);
  wire hit_cd = (paddr_i == `T1MUX_OFF_CCP_DATA);
  wire hit_cdir = (paddr_i == `T1MUX_OFF_CCP_DIR);
  wire hit_ctrl = (paddr_i == `T1MUX_OFF_CTRL);
  wire hit_cnt = (paddr_i == `T1MUX_OFF_COUNT);
  wire hit_any = hit_pd | hit_dir | hit_cd | hit_cdir | hit_ctrl | hit_cnt;
  wire wr_cnt = wr & hit_cnt;
  assign slverr_d = setup & ~hit_any;

  // read mux, unused bits read zero
  assign prdata_d = !setup ? 32'h0000_0000
                  : hit_pd ? {29'h0, port_rd, 1'b0}
                  : hit_dir ? {29'h0, port_dir_q, 1'b0}
                  : hit_cd ? {31'h0, ccp_rd}
                  : hit_cdir ? {31'h0, ccp_dir_q}
                  : hit_ctrl ? {24'h0, ctrl_q}
                  : hit_cnt ? {16'h0, cnt_q}
                  : 32'h0000_0000;

  // bus answer flops
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= setup;
      pslverr_o <= slverr_d;
      prdata_o <= prdata_d;
    end
  end

  // control and direction registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= `T1MUX_RST_CTRL;
      port_dir_q <= `T1MUX_RST_PORT_DIR;
      ccp_dir_q <= `T1MUX_RST_CCP_DIR;
    end else begin
      // upper two bits are unimplemented and stay zero
      if (wr & hit_ctrl) ctrl_q <= pwdata_i[7:0] & `T1MUX_CTRL_WMASK;
      if (wr & hit_dir) port_dir_q <= pwdata_i[2:1];
      if (wr & hit_cdir) ccp_dir_q <= pwdata_i[0];
    end
  end

  // data latches: writes only ever land in the latch
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_lat_q <= `T1MUX_RST_PORT_LAT;
      ccp_dat_q <= `T1MUX_RST_CCP_DAT;
    end else begin
      if (wr & hit_pd) port_lat_q <= pwdata_i[2:1];
      // in oscillator mode the bit cannot be written
      if (wr & hit_cd & ~mode_osc) ccp_dat_q <= pwdata_i[0];
    end
  end

  // counter; a bus write wins over a tick in the same cycle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= `T1MUX_RST_COUNT;
      fw_prev_q <= 1'b0;
    end else begin
      fw_prev_q <= ccp_dat_q;
      if (wr_cnt) cnt_q <= pwdata_i[15:0];
      else if (tick) cnt_q <= cnt_q + 16'h0001;
    end
  end

  // pin and oscillator outputs; the pad oscillator is analog and is not
  // gated by sleep, but the counter steps only on its edges sampled by core_clk_i;
  // software must allow its own start-up delay after enabling it
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin1_o <= 1'b0;
      pin2_o <= 1'b0;
      pin1_oe_n_o <= 1'b1;
      pin2_oe_n_o <= 1'b1;
      sec_osc_en_o <= 1'b0;
      count_o <= `T1MUX_RST_COUNT;
    end else begin
      pin1_o <= pout_d[0];
      pin2_o <= pout_d[1];
      pin1_oe_n_o <= poe_n_d[0];
      pin2_oe_n_o <= poe_n_d[1];
      sec_osc_en_o <= oscen;
      count_o <= cnt_q;
    end
  end

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_plain_pin_drive: assert property (
    mode_plain && !port_dir_q[0] |=> !pin1_oe_n_o && pin1_o == $past(port_lat_q[0]))
    else $error("pin1 not driven from latch in plain mode");
  a_ext_pin_free: assert property (
    mode_ext |=> pin1_oe_n_o)
    else $error("pin1 driven in external clock mode");
  a_fw_pin_drive: assert property (
    mode_fw |=> !pin1_oe_n_o && pin1_o == $past(ccp_dat_q))
    else $error("firmware bit not on pin1");
  a_ext_input_zero: assert property (
    setup && hit_pd && mode_ext && port_dir_q[0] |=> prdata_o[1] == 1'b0)
    else $error("port bit 1 input not zero in counter mode");
  a_osc_swbit_zero: assert property (
    setup && hit_cd && mode_osc |=> prdata_o[0] == 1'b0)
    else $error("clock data bit not zero in oscillator mode");
  a_osc_out_latch: assert property (
    setup && hit_pd && mode_osc && !port_dir_q[1] |=> prdata_o[2] == $past(port_lat_q[1]))
    else $error("port bit 2 output read not latch");
  a_osc_pins_free: assert property (
    mode_osc [*2] |=> pin1_oe_n_o && pin2_oe_n_o)
    else $error("oscillator pins driven");
  a_osc_en_follow: assert property (
    ##1 sec_osc_en_o == $past(oscen))
    else $error("oscillator enable wrong");
  a_stop_holds: assert property (
    !run && !wr_cnt |=> cnt_q == $past(cnt_q))
    else $error("count moved while stopped");
  a_timer_step: assert property (
    mode == T1MUX_TIMER && !wr_cnt |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("timer did not step once");
  a_ext_edge_count: assert property (
    mode_ext && run && sif.rise[0] && !wr_cnt |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("external edge not counted");
  a_restore_drive: assert property (
    $fell(cs) && !oscen && !port_dir_q[0] |=> !pin1_oe_n_o && pin1_o == $past(port_lat_q[0]))
    else $error("pin1 not restored after select cleared");

  c_timer_run: cover property (mode == T1MUX_TIMER ##1 tick);
  c_ext_count: cover property (mode_ext && tick);
  c_fw_count: cover property (mode_fw && tick);
  c_osc_count: cover property (mode_osc && tick);
endmodule // t1mux_top
`default_nettype wire

// ---- testbench/t1mux_ext_src.sv ----
// external clock circuit and crystal model on the two shared port lines
`timescale 1ns/1ps
`default_nettype none
module t1mux_ext_src (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ext_en_i, // external circuit toggles line 1
  input wire logic osc_en_i, // crystal fitted and allowed to swing
  input wire logic sec_osc_en_i, // enable from the device
  input wire logic idle1_i, // level held on line 1 when quiet
  input wire logic idle2_i, // level held on line 2 when quiet
  input wire logic pin1_o_i,
  input wire logic pin1_oe_n_i,
  input wire logic pin2_o_i,
  input wire logic pin2_oe_n_i,
  output logic line1_o,
  output logic line2_o
);
  logic [1:0] ph_q; // half period of four cycles keeps each level above two cycles
  logic lvl1_q; // line 1 level from the external circuit
  logic lvl2_q; // line 2 level from the crystal
  logic osc_run; // crystal swings only while the device enables it
  assign osc_run = osc_en_i & sec_osc_en_i;
  // toggle generators; quiet lines sit at the idle level
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ph_q <= 2'h0;
      lvl1_q <= 1'h0;
      lvl2_q <= 1'h0;
    end else begin
      ph_q <= (ext_en_i | osc_run) ? ph_q + 2'h1 : 2'h0;
      lvl1_q <= ext_en_i ? (lvl1_q ^ (ph_q == 2'h3)) : idle1_i;
      lvl2_q <= osc_run ? (lvl2_q ^ (ph_q == 2'h3)) : idle2_i;
    end
  end
  // wire level: the device wins where it drives
  assign line1_o = pin1_oe_n_i ? lvl1_q : pin1_o_i;
  assign line2_o = pin2_oe_n_i ? lvl2_q : pin2_o_i;
endmodule // t1mux_ext_src
`default_nettype wire

// ---- testbench/tb_timer1_clock_source_port_mux.sv ----
// self-checking bench for the timer1 clock source and port mux
`include "t1mux_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_timer1_clock_source_port_mux;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, a;
  logic pready, pslverr, slv, p1i, p1o, p1oe_n, p2i, p2o, p2oe_n, osc_en, ext_en = 1'b0, xtal = 1'b0;
  logic idle1 = 1'b0, idle2 = 1'b0;
  logic [15:0] count;
  int err_count = 0, comparisons = 0;
  always #25 clk = ~clk; // 20 MHz
  t1mux_top i_t1mux_top (.core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .pin1_i(p1i), .pin1_o(p1o), .pin1_oe_n_o(p1oe_n), .pin2_i(p2i),
    .pin2_o(p2o), .pin2_oe_n_o(p2oe_n), .sec_osc_en_o(osc_en), .count_o(count));
  t1mux_ext_src i_t1mux_ext_src (.core_clk_i(clk), .rst_i(rst), .ext_en_i(ext_en), .osc_en_i(xtal),
    .sec_osc_en_i(osc_en), .idle1_i(idle1), .idle2_i(idle2), .pin1_o_i(p1o), .pin1_oe_n_i(p1oe_n),
    .pin2_o_i(p2o), .pin2_oe_n_i(p2oe_n), .line1_o(p1i), .line2_o(p2i));
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // one apb transfer; wait for pready is bounded
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= ad; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_count++;
      $display("unexpected at %0t: bus hang", $time);
      end_of_test();
    end
    rd = prdata; slv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic pulses(input logic osc);
    @(posedge clk);
    if (osc) xtal <= 1'b1; else ext_en <= 1'b1;
    repeat (40) @(posedge clk);
    xtal <= 1'b0; ext_en <= 1'b0;
    wt(8); // let the synchronisers settle
  endtask
  task automatic t_reset();
    chk({p1oe_n, p2oe_n, osc_en}, 32'h6);
    apb(1'b0, `T1MUX_OFF_CTRL, 32'h0); chk(rd, 32'h0);
    apb(1'b0, `T1MUX_OFF_PORT_DIR, 32'h0); chk(rd, 32'h6);
    apb(1'b0, `T1MUX_OFF_CCP_DIR, 32'h0); chk(rd, 32'h1);
    apb(1'b0, `T1MUX_OFF_COUNT, 32'h0); chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0); chk({slv, rd}, {1'b1, 32'h0});
    apb(1'b1, `T1MUX_OFF_CTRL, 32'hff); apb(1'b0, `T1MUX_OFF_CTRL, 32'h0); chk(rd, 32'h3f);
    $display("test reset done");
  endtask
  task automatic t_timer();
    apb(1'b1, `T1MUX_OFF_CTRL, 32'h1); apb(1'b1, `T1MUX_OFF_PORT_DIR, 32'h0);
    apb(1'b1, `T1MUX_OFF_PORT_DATA, 32'h6); wt(2);
    chk({p1o, p1oe_n, p2o, p2oe_n}, 32'ha);
    apb(1'b0, `T1MUX_OFF_COUNT, 32'h0); a = rd; apb(1'b0, `T1MUX_OFF_COUNT, 32'h0);
    chk(rd - a, 32'h3);
    apb(1'b1, `T1MUX_OFF_CTRL, 32'h0);
    apb(1'b0, `T1MUX_OFF_COUNT, 32'h0); a = rd; apb(1'b0, `T1MUX_OFF_COUNT, 32'h0);
    chk(rd, a);
    chk(count, a);
    $display("test timer done");
  endtask
  task automatic t_ext();
    apb(1'b1, `T1MUX_OFF_PORT_DIR, 32'h6); apb(1'b1, `T1MUX_OFF_CTRL, 32'h3);
    apb(1'b0, `T1MUX_OFF_COUNT, 32'h0); a = rd; pulses(1'b0);
    apb(1'b0, `T1MUX_OFF_COUNT, 32'h0); chk(rd - a, 32'h5);
    idle1 <= 1'b1; idle2 <= 1'b1; wt(8);
    apb(1'b0, `T1MUX_OFF_CCP_DATA, 32'h0); chk(rd, 32'h1);
    apb(1'b0, `T1MUX_OFF_PORT_DATA, 32'h0); chk(rd & 32'h6, 32'h4);
    apb(1'b1, `T1MUX_OFF_PORT_DIR, 32'h4); apb(1'b1, `T1MUX_OFF_PORT_DATA, 32'h2);
    apb(1'b0, `T1MUX_OFF_PORT_DATA, 32'h0); wt(1); chk({rd[1], p1oe_n}, 32'h3);
    apb(1'b1, `T1MUX_OFF_CTRL, 32'h1); wt(2); chk({p1o, p1oe_n}, 32'h2);
    idle1 <= 1'b0; idle2 <= 1'b0;
    $display("test external clock done");
  endtask
  task automatic t_fw();
    apb(1'b1, `T1MUX_OFF_CCP_DIR, 32'h0); apb(1'b1, `T1MUX_OFF_CTRL, 32'h3);
    apb(1'b1, `T1MUX_OFF_CCP_DATA, 32'h0); apb(1'b0, `T1MUX_OFF_COUNT, 32'h0); a = rd;
    apb(1'b1, `T1MUX_OFF_CCP_DATA, 32'h1); apb(1'b0, `T1MUX_OFF_CCP_DATA, 32'h0);
    chk({rd[0], p1o, p1oe_n}, 32'h6);
    apb(1'b0, `T1MUX_OFF_COUNT, 32'h0); chk(rd - a, 32'h1);
    apb(1'b1, `T1MUX_OFF_CCP_DIR, 32'h1);
    $display("test firmware clock done");
  endtask
  task automatic t_osc();
    apb(1'b1, `T1MUX_OFF_CTRL, 32'hb); wt(2); chk({osc_en, p1oe_n, p2oe_n}, 32'h7);
    apb(1'b1, `T1MUX_OFF_CCP_DATA, 32'h1); apb(1'b0, `T1MUX_OFF_CCP_DATA, 32'h0); chk(rd, 32'h0);
    apb(1'b1, `T1MUX_OFF_PORT_DIR, 32'h0); apb(1'b1, `T1MUX_OFF_PORT_DATA, 32'h6);
    apb(1'b0, `T1MUX_OFF_PORT_DATA, 32'h0); wt(1); chk({rd[2:1], p1oe_n, p2oe_n}, 32'hf);
    apb(1'b1, `T1MUX_OFF_PORT_DIR, 32'h6); idle1 <= 1'b1; idle2 <= 1'b1; wt(8);
    apb(1'b0, `T1MUX_OFF_PORT_DATA, 32'h0); chk(rd & 32'h6, 32'h0);
    idle1 <= 1'b0; idle2 <= 1'b0; wt(8);
    // oscillator was enabled well before this point: software start-up delay kept
    apb(1'b0, `T1MUX_OFF_COUNT, 32'h0); a = rd; pulses(1'b1);
    apb(1'b0, `T1MUX_OFF_COUNT, 32'h0); chk(rd - a, 32'h5);
    apb(1'b1, `T1MUX_OFF_CTRL, 32'h0); apb(1'b1, `T1MUX_OFF_PORT_DIR, 32'h0); wt(2);
    chk({osc_en, p1o, p1oe_n, p2o, p2oe_n}, 32'ha);
    $display("test oscillator done");
  endtask
  // main sequence: reset for four cycles, then the scenarios
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_timer();
    t_ext();
    t_fw();
    t_osc();
    end_of_test();
  end
endmodule // tb_timer1_clock_source_port_mux
`default_nettype wire
